// ==== rtl/ccr_device.sv ====
// converter end: serial slave, three configuration registers and their control outputs
// How it works
// - pin select: high pin powers down or aligns
// - trigger toggle aligns; bit is not self-clearing
// - host sets align enable with the trigger
// - align enable picks register over pin
// - source bit: pin or register picks reference
// - reference codes: internal, buffered external, direct
// - host sets source bit for non-internal reference codes
// - single-ended clock powers differential buffer down
// - host sets source bit for clock select
// - channel A single-ended when bit set
// - channel B single-ended when bit set
// - fast grade: delay loop down, half period
// - host sets delay loop down only slow
// - auto-zero switch, reset by speed grade
// - host pulses fuse load after interface setup
// - fuse load restores earlier writes to reset
// - host does interface and fuse load first
// - global down spares masked blocks
//
// The strobed register port is this design's own decision.
module ccr_device #(
  parameter logic FAST_GRADE = 1'b0  // fastest speed grade
) (
  input  wire logic       clock,          // 25 MHz clock
  input  wire logic       arst_n,         // async reset, active low
  ccr_link_if.device      link,           // serial link and pins
  input  wire logic       clkBufExempt,   // keep clock buffer in global down
  input  wire logic       refAmpExempt,   // keep reference amplifier in global down
  input  wire logic       bandgapDownEn,  // let bandgap go down in global down
  output logic            globalDown,     // global power down
  output logic            alignPulse,     // one-cycle alignment command
  output logic            refFromPin,     // reference chosen by pin
  output logic            refInternal,    // internal reference
  output logic            refExtBuffered, // external reference via buffer
  output logic            refExtDirect,   // direct external reference
  output logic            seClock,        // single-ended clock input
  output logic            clkBufDown,     // differential clock buffer down
  output logic            refAmpDown,     // reference amplifier down
  output logic            bandgapDown,    // bandgap down
  output logic            seInputA,       // channel A single-ended
  output logic            seInputB,       // channel B single-ended
  output logic            delayLoopDown,  // delay loop powered down
  output logic            sampleHalf,     // sampling time half period
  output logic            autoZero,       // auto-zero on
  output logic            fuseLoaded      // one-cycle fuse-map load
);
  localparam logic [7:0] RST_AZ = ccr_pkg::RST_INPUT_AZ | {7'h00, ~FAST_GRADE};

  logic                  sclkQ;
  logic [ccr_pkg::CNT_W-1:0] bitCntQ;
  logic [ccr_pkg::FRAME_W-2:0] inShQ;
  logic [ccr_pkg::DW-1:0] outShQ;
  logic                  isReadQ;
  logic                  misoQ;
  logic                  misoOeQ;
  logic [7:0]            alignRefQ;
  logic [7:0]            inputAzQ;
  logic [7:0]            fuseQ;
  logic                  syncQ;
  logic                  rise;
  logic                  fall;
  logic                  wrStb;
  logic [ccr_pkg::AW-1:0] wrAddr;
  logic [7:0]            wrData;
  logic [ccr_pkg::AW-1:0] rdAddr;
  logic [7:0]            rdByte;
  logic                  fuseEvent;

  assign link.miso   = misoQ;
  assign link.misoOe = misoOeQ;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave
  assign rise   = link.sclk & ~sclkQ;
  assign fall   = ~link.sclk & sclkQ;
  assign wrStb  = rise & ~link.csN & ~isReadQ & (bitCntQ == ccr_pkg::LAST_BIT);
  assign wrAddr = inShQ[ccr_pkg::FRAME_W-3:ccr_pkg::DW-1];
  assign wrData = {inShQ[ccr_pkg::DW-2:0], link.mosi};
  assign rdAddr = {inShQ[ccr_pkg::AW-2:0], link.mosi};

  always_comb begin
    unique case (rdAddr)
      ccr_pkg::ADDR_ALIGN_REF: rdByte = alignRefQ;
      ccr_pkg::ADDR_INPUT_AZ:  rdByte = inputAzQ;
      ccr_pkg::ADDR_FUSE:      rdByte = fuseQ;
      default:                 rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sclkQ   <= 1'b0;
      bitCntQ <= '0;
      inShQ   <= '0;
      outShQ  <= '0;
      isReadQ <= 1'b0;
      misoQ   <= 1'b0;
      misoOeQ <= 1'b0;
    end else begin
      sclkQ <= link.sclk;
      if (link.csN) begin
        bitCntQ <= '0;
        misoOeQ <= 1'b0;
        misoQ   <= 1'b0;
      end else begin
        if (rise) begin
          inShQ   <= {inShQ[ccr_pkg::FRAME_W-3:0], link.mosi};
          bitCntQ <= bitCntQ + 5'h01;
          if (bitCntQ == ccr_pkg::HDR_LAST) begin
            isReadQ <= inShQ[ccr_pkg::AW-1];
            outShQ  <= rdByte;
          end
        end
        // data goes out on the falling edge so the host samples it settled
        if (fall && isReadQ && bitCntQ >= ccr_pkg::HDR_BITS && bitCntQ < ccr_pkg::FRAME_BITS) begin
          misoQ   <= outShQ[ccr_pkg::DW-1];
          outShQ  <= {outShQ[ccr_pkg::DW-2:0], 1'b0};
          misoOeQ <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // load takes effect on the 1 to 0 write of the load bit
  assign fuseEvent = wrStb && wrAddr == ccr_pkg::ADDR_FUSE
                     && fuseQ[ccr_pkg::BIT_FUSE_LD] && !wrData[ccr_pkg::BIT_FUSE_LD];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alignRefQ <= ccr_pkg::RST_ALIGN_REF;
      inputAzQ  <= RST_AZ;
      fuseQ     <= ccr_pkg::RST_FUSE;
    end else if (fuseEvent) begin
      alignRefQ <= ccr_pkg::RST_ALIGN_REF;
      inputAzQ  <= RST_AZ;
      fuseQ     <= wrData;
    end else if (wrStb) begin
      // reserved bits are kept as written
      unique case (wrAddr)
        ccr_pkg::ADDR_ALIGN_REF: alignRefQ <= wrData;
        ccr_pkg::ADDR_INPUT_AZ:  inputAzQ  <= wrData;
        ccr_pkg::ADDR_FUSE:      fuseQ     <= wrData;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alignment and power down
  logic regAlignHit;
  logic pinAlignHit;
  logic gdNext;
  assign regAlignHit = wrStb && !fuseEvent && wrAddr == ccr_pkg::ADDR_ALIGN_REF
                       && wrData[ccr_pkg::BIT_ALIGN_EN]
                       && (wrData[ccr_pkg::BIT_ALIGN_TRG] != alignRefQ[ccr_pkg::BIT_ALIGN_TRG]);
  assign pinAlignHit = link.syncPdn && !syncQ && alignRefQ[ccr_pkg::BIT_PIN_FUNC]
                       && !alignRefQ[ccr_pkg::BIT_ALIGN_EN];
  assign gdNext = link.syncPdn && !alignRefQ[ccr_pkg::BIT_PIN_FUNC];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncQ       <= 1'b0;
      alignPulse  <= 1'b0;
      fuseLoaded  <= 1'b0;
      globalDown  <= 1'b0;
      refAmpDown  <= 1'b0;
      bandgapDown <= 1'b0;
    end else begin
      syncQ       <= link.syncPdn;
      alignPulse  <= regAlignHit | pinAlignHit;
      fuseLoaded  <= fuseEvent;
      globalDown  <= gdNext;
      refAmpDown  <= gdNext & ~refAmpExempt;
      bandgapDown <= gdNext & bandgapDownEn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference, clock and input decode
  logic       refCtl;
  logic [1:0] refSel;
  logic       seClkNext;
  assign refCtl    = alignRefQ[ccr_pkg::BIT_REFERENCE_CONTROL_SOURCE];
  assign refSel    = alignRefQ[ccr_pkg::BIT_REF_SEL+1:ccr_pkg::BIT_REF_SEL];
  assign seClkNext = refCtl & alignRefQ[ccr_pkg::BIT_SE_CLK];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refFromPin     <= 1'b1;
      refInternal    <= 1'b0;
      refExtBuffered <= 1'b0;
      refExtDirect   <= 1'b0;
      seClock        <= 1'b0;
      clkBufDown     <= 1'b0;
      seInputA       <= 1'b0;
      seInputB       <= 1'b0;
      delayLoopDown  <= 1'b0;
      sampleHalf     <= 1'b0;
      autoZero       <= 1'b0;
    end else begin
      refFromPin     <= ~refCtl;
      refInternal    <= refCtl && refSel == ccr_pkg::REF_INTERNAL;
      refExtBuffered <= refCtl && refSel == ccr_pkg::REF_EXT_BUF;
      refExtDirect   <= refCtl && refSel == ccr_pkg::REF_EXT_DIR;
      seClock        <= seClkNext;
      // differential buffer also drops in unmasked global down
      clkBufDown     <= seClkNext | (gdNext & ~clkBufExempt);
      seInputA       <= inputAzQ[ccr_pkg::BIT_SE_A];
      seInputB       <= inputAzQ[ccr_pkg::BIT_SE_B];
      delayLoopDown  <= FAST_GRADE & inputAzQ[ccr_pkg::BIT_DELAY_LOOP_POWERDOWN];
      sampleHalf     <= FAST_GRADE & inputAzQ[ccr_pkg::BIT_DELAY_LOOP_POWERDOWN];
      autoZero       <= inputAzQ[ccr_pkg::BIT_AUTO_ZERO_ENABLE];
    end
  end
endmodule // ccr_device

// ==== rtl/ccr_pkg.sv ====
// shared constants and types for the converter configuration link
package ccr_pkg;
  // serial frame: read flag, 7-bit address, 8-bit data, msb first
  localparam int        FRAME_W  = 16;
  localparam int        HDR_W    = 8;
  localparam int        AW       = 7;
  localparam int        DW       = 8;
  localparam int        CNT_W    = 5;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // device register map
  localparam logic [6:0] ADDR_ALIGN_REF = 7'h0E;
  localparam logic [6:0] ADDR_INPUT_AZ  = 7'h11;
  localparam logic [6:0] ADDR_FUSE      = 7'h13;
  localparam logic [6:0] ADDR_OUT_IF    = 7'h07;
  localparam logic [7:0] RST_ALIGN_REF  = 8'h00;
  localparam logic [7:0] RST_INPUT_AZ   = 8'h00;
  localparam logic [7:0] RST_FUSE       = 8'h00;

  // fields of the align / reference / clock register
  localparam int BIT_PIN_FUNC  = 7;
  localparam int BIT_ALIGN_TRG = 6;
  localparam int BIT_ALIGN_EN  = 5;
  localparam int BIT_REFERENCE_CONTROL_SOURCE   = 3;
  localparam int BIT_REF_SEL   = 1;
  localparam int BIT_SE_CLK    = 0;
  localparam logic [7:0] RSV_ALIGN_REF = 8'h10;
  // fields of the input / auto-zero register
  localparam int BIT_SE_A      = 5;
  localparam int BIT_SE_B      = 4;
  localparam int BIT_DELAY_LOOP_POWERDOWN   = 2;
  localparam int BIT_AUTO_ZERO_ENABLE     = 0;
  localparam logic [7:0] RSV_INPUT_AZ = 8'hCA;
  // fuse-map load register
  localparam int BIT_FUSE_LD   = 0;
  localparam logic [7:0] RSV_FUSE = 8'hFE;

  // reference select codes
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXT_BUF  = 2'h1;
  localparam logic [1:0] REF_EXT_DIR  = 2'h2;

  // host command registers
  localparam logic [3:0] HREG_ADDR   = 4'h0;
  localparam logic [3:0] HREG_WDATA  = 4'h1;
  localparam logic [3:0] HREG_CTRL   = 4'h2;
  localparam logic [3:0] HREG_STATUS = 4'h3;
  localparam logic [3:0] HREG_RDATA  = 4'h4;
  localparam logic [3:0] HREG_PINS   = 4'h5;
  localparam int HBIT_START = 0;
  localparam int HBIT_READ  = 1;
  localparam int HBIT_BUSY  = 0;
  localparam int HBIT_DONE  = 1;
  localparam int HBIT_FUSED = 2;
  localparam int HBIT_ORDER = 3;
  localparam int HBIT_SYNC  = 0;
  localparam int HBIT_REFB  = 1;

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} ccr_hstate_t;
endpackage : ccr_pkg

// ==== rtl/ccr_link_if.sv ====
// serial configuration link and shared control pins between host and converter
interface ccr_link_if;
  logic sclk;       // serial clock, host made
  logic csN;        // frame select, active low
  logic mosi;       // host to device data
  logic miso;       // device to host data
  logic misoOe;     // device drives miso
  logic syncPdn;    // shared align / power-down pin
  logic refBufPin;  // reference select pin
  modport device (input sclk, csN, mosi, syncPdn, refBufPin, output miso, misoOe);
  modport host   (output sclk, csN, mosi, syncPdn, refBufPin, input miso, misoOe);
endinterface : ccr_link_if

// ==== rtl/ccr_host.sv ====
// host end: command registers driving serial frames and the shared pins
module ccr_host #(
  parameter int   HALF_DIV      = 4,    // clocks per serial half period, at least 2
  parameter logic SLOW_SAMPLING = 1'b0  // sampling rate below the delay loop limit
) (
  input  wire logic       clock,   // 25 MHz clock
  input  wire logic       arst_n,  // async reset, active low
  ccr_link_if.host        link,    // serial link and pins
  input  wire logic [3:0] addr,    // command register address
  input  wire logic [7:0] wdata,   // write data
  input  wire logic       wr,      // write strobe
  input  wire logic       rd,      // read strobe
  output logic      [7:0] rdata    // read data, cycle after rd
);
  localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

  ccr_pkg::ccr_hstate_t stateQ;
  logic [7:0]  divQ;
  logic [4:0]  bitQ;
  logic [15:0] shQ;
  logic [7:0]  rxQ;
  logic [6:0]  addrQ;
  logic [7:0]  wdataQ;
  logic [7:0]  rdataQ;
  logic        doneQ;
  logic        fusedQ;
  logic        fuseArmQ;
  logic        orderErrQ;
  logic        readQ;
  logic        sclkQ;
  logic        csNQ;
  logic        mosiQ;
  logic [1:0]  pinsQ;
  logic        start;
  logic        frameEnd;
  logic [7:0]  outData;

  assign link.sclk      = sclkQ;
  assign link.csN       = csNQ;
  assign link.mosi      = mosiQ;
  assign link.syncPdn   = pinsQ[ccr_pkg::HBIT_SYNC];
  assign link.refBufPin = pinsQ[ccr_pkg::HBIT_REFB];

  assign start = wr && addr == ccr_pkg::HREG_CTRL && wdata[ccr_pkg::HBIT_START]
                 && stateQ == ccr_pkg::H_IDLE;
  assign frameEnd = stateQ == ccr_pkg::H_END && divQ == DIV_LAST;

  // write data cleaned up before it goes out
  always_comb begin
    outData = wdataQ;
    unique case (addrQ)
      ccr_pkg::ADDR_ALIGN_REF: begin
        outData = wdataQ & ~ccr_pkg::RSV_ALIGN_REF;
        if (wdataQ[ccr_pkg::BIT_ALIGN_TRG]) outData[ccr_pkg::BIT_ALIGN_EN] = 1'b1;
        if (wdataQ[ccr_pkg::BIT_REF_SEL+1:ccr_pkg::BIT_REF_SEL] != ccr_pkg::REF_INTERNAL
            || wdataQ[ccr_pkg::BIT_SE_CLK]) outData[ccr_pkg::BIT_REFERENCE_CONTROL_SOURCE] = 1'b1;
      end
      ccr_pkg::ADDR_INPUT_AZ: begin
        outData = wdataQ & ~ccr_pkg::RSV_INPUT_AZ;
        if (!SLOW_SAMPLING) outData[ccr_pkg::BIT_DELAY_LOOP_POWERDOWN] = 1'b0;
      end
      ccr_pkg::ADDR_FUSE: outData = wdataQ & ~ccr_pkg::RSV_FUSE;
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= ccr_pkg::H_IDLE;
      divQ   <= 8'h00;
      bitQ   <= 5'h00;
      shQ    <= 16'h0000;
      rxQ    <= 8'h00;
      sclkQ  <= 1'b0;
      csNQ   <= 1'b1;
      mosiQ  <= 1'b0;
    end else begin
      unique case (stateQ)
        ccr_pkg::H_IDLE: if (start) begin
          stateQ <= ccr_pkg::H_LOW;
          shQ    <= {wdata[ccr_pkg::HBIT_READ], addrQ, outData};
          mosiQ  <= wdata[ccr_pkg::HBIT_READ];
          csNQ   <= 1'b0;
          divQ   <= 8'h00;
          bitQ   <= 5'h00;
        end
        ccr_pkg::H_LOW: if (divQ == DIV_LAST) begin
          sclkQ  <= 1'b1;
          divQ   <= 8'h00;
          stateQ <= ccr_pkg::H_HIGH;
          if (bitQ >= ccr_pkg::HDR_BITS) rxQ <= {rxQ[6:0], link.miso};
        end else divQ <= divQ + 8'h01;
        ccr_pkg::H_HIGH: if (divQ == DIV_LAST) begin
          sclkQ <= 1'b0;
          divQ  <= 8'h00;
          bitQ  <= bitQ + 5'h01;
          shQ   <= {shQ[14:0], 1'b0};
          mosiQ <= shQ[14];
          stateQ <= (bitQ == ccr_pkg::LAST_BIT) ? ccr_pkg::H_END : ccr_pkg::H_LOW;
        end else divQ <= divQ + 8'h01;
        ccr_pkg::H_END: if (divQ == DIV_LAST) begin
          csNQ   <= 1'b1;
          mosiQ  <= 1'b0;
          stateQ <= ccr_pkg::H_IDLE;
        end else divQ <= divQ + 8'h01;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command registers and status
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addrQ  <= 7'h00;
      wdataQ <= 8'h00;
      pinsQ  <= 2'h0;
      readQ  <= 1'b0;
    end else if (wr) begin
      if (addr == ccr_pkg::HREG_ADDR && stateQ == ccr_pkg::H_IDLE) addrQ <= wdata[6:0];
      if (addr == ccr_pkg::HREG_WDATA && stateQ == ccr_pkg::H_IDLE) wdataQ <= wdata;
      if (addr == ccr_pkg::HREG_PINS) pinsQ <= wdata[1:0];
      if (start) readQ <= wdata[ccr_pkg::HBIT_READ];
    end
  end

  // fuse load is the 1 then 0 write; writes to registers other than the interface and fuse ones before it flag order error
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      doneQ     <= 1'b0;
      fusedQ    <= 1'b0;
      fuseArmQ  <= 1'b0;
      orderErrQ <= 1'b0;
      rdataQ    <= 8'h00;
    end else begin
      if (rd && addr == ccr_pkg::HREG_STATUS) begin
        doneQ     <= 1'b0;
        orderErrQ <= 1'b0;
      end
      if (frameEnd) begin
        doneQ <= 1'b1;
        if (readQ) rdataQ <= rxQ;
        else if (addrQ == ccr_pkg::ADDR_FUSE) begin
          fuseArmQ <= outData[ccr_pkg::BIT_FUSE_LD];
          if (fuseArmQ && !outData[ccr_pkg::BIT_FUSE_LD]) fusedQ <= 1'b1;
        end else if (addrQ != ccr_pkg::ADDR_OUT_IF && !fusedQ) orderErrQ <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rdata <= 8'h00;
    else if (rd) begin
      unique case (addr)
        ccr_pkg::HREG_ADDR:   rdata <= {1'b0, addrQ};
        ccr_pkg::HREG_WDATA:  rdata <= wdataQ;
        ccr_pkg::HREG_STATUS: rdata <= {4'h0, orderErrQ, fusedQ, doneQ, stateQ != ccr_pkg::H_IDLE};
        ccr_pkg::HREG_RDATA:  rdata <= rdataQ;
        ccr_pkg::HREG_PINS:   rdata <= {6'h00, pinsQ};
        default:              rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end
endmodule // ccr_host

// ==== sim/ccr_sva.sv ====
// concurrent checks on the configuration link and the converter control outputs
module ccr_sva (
  input wire logic clock,          // system clock
  input wire logic arst_n,         // async reset, active low
  input wire logic sclk,           // serial clock
  input wire logic csN,            // frame select, active low
  input wire logic misoOe,         // device drives miso
  input wire logic syncPdn,        // shared align / power-down pin
  input wire logic globalDown,     // global power down
  input wire logic alignPulse,     // alignment command
  input wire logic fuseLoaded,     // fuse-map load
  input wire logic clkBufExempt,   // clock buffer mask
  input wire logic refAmpExempt,   // reference amplifier mask
  input wire logic bandgapDownEn,  // bandgap mask
  input wire logic clkBufDown,     // clock buffer down
  input wire logic refAmpDown,     // reference amplifier down
  input wire logic bandgapDown,    // bandgap down
  input wire logic seClock,        // single-ended clock
  input wire logic refFromPin,     // reference by pin
  input wire logic refInternal,    // internal reference
  input wire logic refExtBuffered, // buffered external reference
  input wire logic refExtDirect    // direct external reference
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // held for two samples, so one-cycle lag of the mask outputs is tolerated
  sequence gd_held;
    globalDown && $past(globalDown);
  endsequence
  sequence up_held;
    !globalDown && !$past(globalDown) && !seClock && !$past(seClock);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  pd_rise_a : assert property ($rose(globalDown) |-> $past(syncPdn))
    else $error("global down rose without the pin");
  align_once_a : assert property (alignPulse |=> !alignPulse)
    else $error("alignment pulse longer than one cycle");
  fuse_once_a : assert property (fuseLoaded |=> !fuseLoaded)
    else $error("fuse load pulse longer than one cycle");
  clkbuf_down_a : assert property (gd_held ##0 (!clkBufExempt && $stable(clkBufExempt))
    |-> clkBufDown) else $error("clock buffer kept up in global down");
  refamp_down_a : assert property (gd_held ##0 $stable(refAmpExempt)
    |-> refAmpDown == !refAmpExempt) else $error("reference amplifier ignores its mask");
  bandgap_down_a : assert property (gd_held ##0 $stable(bandgapDownEn)
    |-> bandgapDown == bandgapDownEn) else $error("bandgap ignores its mask");
  all_up_a : assert property (up_held |-> !clkBufDown && !refAmpDown && !bandgapDown)
    else $error("block powered down outside global down");
  se_clock_a : assert property (seClock && $past(seClock) |-> clkBufDown)
    else $error("differential buffer up with single-ended clock");
  ref_decode_a : assert property ($onehot0({refInternal, refExtBuffered, refExtDirect}))
    else $error("two reference options at once");
  ref_pin_a : assert property (refFromPin |-> !(refInternal || refExtBuffered || refExtDirect))
    else $error("register reference active in pin mode");
  sclk_idle_a : assert property (csN |-> !sclk)
    else $error("serial clock high outside a frame");
  miso_free_a : assert property (csN && $past(csN) |-> !misoOe)
    else $error("miso driven outside a frame");
endmodule // ccr_sva

// ==== sim/testbench.sv ====
// self-checking bench: host command port drives frames into the converter end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, arst_n, wr, rd, clkBufExempt, refAmpExempt, bandgapDownEn;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, got;
  logic       globalDown, alignPulse, refFromPin, refInternal, refExtBuffered, refExtDirect;
  logic       seClock, clkBufDown, refAmpDown, bandgapDown, seInputA, seInputB;
  logic       delayLoopDown, sampleHalf, autoZero, fuseLoaded;
  int         err_total = 0, samples_checked = 0, alignCnt = 0, fuseCnt = 0;

  ccr_link_if link ();
  ccr_host #(.HALF_DIV(2), .SLOW_SAMPLING(1'b1)) i_ccr_host (.clock(clock), .arst_n(arst_n),
    .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ccr_device #(.FAST_GRADE(1'b1)) i_ccr_device (.clock(clock), .arst_n(arst_n), .link(link),
    .clkBufExempt(clkBufExempt), .refAmpExempt(refAmpExempt), .bandgapDownEn(bandgapDownEn),
    .globalDown(globalDown), .alignPulse(alignPulse), .refFromPin(refFromPin),
    .refInternal(refInternal), .refExtBuffered(refExtBuffered), .refExtDirect(refExtDirect),
    .seClock(seClock), .clkBufDown(clkBufDown), .refAmpDown(refAmpDown),
    .bandgapDown(bandgapDown), .seInputA(seInputA), .seInputB(seInputB),
    .delayLoopDown(delayLoopDown), .sampleHalf(sampleHalf), .autoZero(autoZero),
    .fuseLoaded(fuseLoaded));
  ccr_sva i_ccr_sva (.clock(clock), .arst_n(arst_n), .sclk(link.sclk), .csN(link.csN),
    .misoOe(link.misoOe), .syncPdn(link.syncPdn), .globalDown(globalDown),
    .alignPulse(alignPulse), .fuseLoaded(fuseLoaded), .clkBufExempt(clkBufExempt),
    .refAmpExempt(refAmpExempt), .bandgapDownEn(bandgapDownEn), .clkBufDown(clkBufDown),
    .refAmpDown(refAmpDown), .bandgapDown(bandgapDown), .seClock(seClock),
    .refFromPin(refFromPin), .refInternal(refInternal), .refExtBuffered(refExtBuffered),
    .refExtDirect(refExtDirect));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (alignPulse === 1'b1) alignCnt++;
    if (fuseLoaded === 1'b1) fuseCnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic hwr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic hrd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  // one device frame, then poll busy under a bound
  task automatic dev(input logic [6:0] a, input logic [7:0] d, input logic rdf);
    logic [7:0] s;
    int         n;
    hwr(ccr_pkg::HREG_ADDR, {1'b0, a});
    hwr(ccr_pkg::HREG_WDATA, d);
    hwr(ccr_pkg::HREG_CTRL, {6'h00, rdf, 1'b1});
    s = 8'h01;
    n = 0;
    while (s[ccr_pkg::HBIT_BUSY] !== 1'b0 && n < 100) begin
      hrd(ccr_pkg::HREG_STATUS, s);
      n++;
    end
    if (n == 100) chk(8'hFF, 8'h00);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    dev(a, 8'h00, 1'b1);
    hrd(ccr_pkg::HREG_RDATA, got);
    chk(got, e);
  endtask
  task automatic pin(input logic [7:0] v);
    hwr(ccr_pkg::HREG_PINS, v);
    repeat (6) @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    clkBufExempt = 1'b0; refAmpExempt = 1'b0; bandgapDownEn = 1'b0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk({4'h0, refFromPin, autoZero, seInputA, globalDown}, 8'h08);
    rdchk(ccr_pkg::ADDR_ALIGN_REF, 8'h00);
    rdchk(ccr_pkg::ADDR_INPUT_AZ, 8'h00);
    rdchk(ccr_pkg::ADDR_FUSE, 8'h00);
    // interface setup and fuse load come first, earlier writes would be lost
    dev(ccr_pkg::ADDR_OUT_IF, 8'h00, 1'b0);
    dev(ccr_pkg::ADDR_FUSE, 8'h01, 1'b0);
    dev(ccr_pkg::ADDR_FUSE, 8'h00, 1'b0);
    chk(fuseCnt[7:0], 8'h01);
    // done was cleared by the last busy poll, so only the fuse flag stands
    hrd(ccr_pkg::HREG_STATUS, got);
    chk(got, 8'h04);
    dev(ccr_pkg::ADDR_INPUT_AZ, 8'h35, 1'b0);
    chk({2'h0, seInputA, seInputB, delayLoopDown, sampleHalf, 1'b0, autoZero}, 8'h3D);
    rdchk(ccr_pkg::ADDR_INPUT_AZ, 8'h35);
    for (int i = 0; i < 4; i++) begin
      dev(ccr_pkg::ADDR_ALIGN_REF, {5'h01, i[1:0], 1'b0}, 1'b0);
      chk({4'h0, refFromPin, refInternal, refExtBuffered, refExtDirect},
          {5'h00, i == 0, i == 1, i == 2});
    end
    dev(ccr_pkg::ADDR_ALIGN_REF, 8'h09, 1'b0);
    chk({6'h00, seClock, clkBufDown}, 8'h03);
    dev(ccr_pkg::ADDR_ALIGN_REF, 8'h08, 1'b0);
    chk({6'h00, seClock, clkBufDown}, 8'h00);
    for (int m = 0; m < 2; m++) begin
      @(posedge clock);
      clkBufExempt  <= m[0];
      refAmpExempt  <= !m[0];
      bandgapDownEn <= m[0];
      pin(8'h01);
      chk({4'h1, clkBufDown, refAmpDown, bandgapDown, alignPulse},
          {4'h1, !m[0], m[0], m[0], 1'b0});
      chk({7'h00, globalDown}, 8'h01);
      pin(8'h00);
      chk({4'h0, globalDown, clkBufDown, refAmpDown, bandgapDown}, 8'h00);
    end
    dev(ccr_pkg::ADDR_ALIGN_REF, 8'h20, 1'b0);
    dev(ccr_pkg::ADDR_ALIGN_REF, 8'h60, 1'b0);
    rdchk(ccr_pkg::ADDR_ALIGN_REF, 8'h60);
    dev(ccr_pkg::ADDR_ALIGN_REF, 8'h20, 1'b0);
    chk(alignCnt[7:0], 8'h02);
    // pin function set but register alignment still owns the command
    dev(ccr_pkg::ADDR_ALIGN_REF, 8'hA0, 1'b0);
    pin(8'h01);
    pin(8'h00);
    dev(ccr_pkg::ADDR_ALIGN_REF, 8'h80, 1'b0);
    pin(8'h01);
    chk({7'h00, globalDown}, 8'h00);
    pin(8'h00);
    chk(alignCnt[7:0], 8'h03);
    dev(ccr_pkg::ADDR_FUSE, 8'h01, 1'b0);
    dev(ccr_pkg::ADDR_FUSE, 8'h00, 1'b0);
    chk(fuseCnt[7:0], 8'h02);
    rdchk(ccr_pkg::ADDR_ALIGN_REF, 8'h00);
    rdchk(ccr_pkg::ADDR_INPUT_AZ, 8'h00);
    rdchk(ccr_pkg::ADDR_FUSE, 8'h00);
    test_done;
  end
  initial begin
    repeat (25000) @(posedge clock);
    err_total++;
    test_done;
  end
endmodule // testbench
